// ---- core/psfs_pin_mux.sv ----
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
//
// Contract
// - pa3: port, timer1 out, analog ch7
// - pa1: port with irq0, analog ch6
// - pa7: port, timer0 inv, spi din, rx
// - pa6: port, spi dout, uart tx
// - pa5: port, timer1 inv, spi cs
// - pa4: port, spi clock on 01
// - pb3: port, amp positive input on 01
// - pb2: port with irq1, low-volt detect
// - pb6: port, spi dout, uart tx
// - pb5: port, spi din, rx, analog ch5
// - pb4: port with timer clock, amp, ch4
// - pc0: port, timer0 out on 01
// - spi din source: pb5 or pa7
// - rx source: pa7 or pb5
// - bit1 picks segment30 or common5
// - bit0 picks segment31 or common4
// - unimplemented bits read zero, ignore writes
// - reset sets port data and direction
// - bit set/clear is read-modify-write
// - enabled port a falling edge wakes
// - direction 1 input, 0 output; read latch
//
module psfs_pin_mux #(
    parameter int ADDR_W = 4
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic [7:0] pa_pin_in,
    output logic [7:0] pa_pin_out,
    output logic [7:0] pa_pin_oe_out,
    input wire logic [7:0] pb_pin_in,
    output logic [7:0] pb_pin_out,
    output logic [7:0] pb_pin_oe_out,
    input wire logic pc0_pin_in,
    output logic pc0_pin_out,
    output logic pc0_pin_oe_out,
    input wire psfs_pkg::psfs_periph_t periph_in,
    output psfs_pkg::psfs_periph_in_t periph_out,
    output psfs_pkg::psfs_analog_t analog_sel_out,
    output logic lcd_common_5_sel_out,
    output logic lcd_common_4_sel_out,
    input wire logic sleep_in,
    output logic wake_out
);

    logic [7:0] pa_sel_lo_r;
    logic [7:0] pa_sel_hi_r;
    logic [7:0] pb_sel_lo_r;
    logic [7:0] pb_sel_hi_r;
    logic [7:0] pc_sel_r;
    logic [7:0] in_src_r;
    logic [7:0] disp_sel_r;
    logic [7:0] pa_data_r;
    logic [7:0] pa_dir_r;
    logic [7:0] pa_wake_r;
    logic [7:0] pb_data_r;
    logic [7:0] pb_dir_r;
    logic [7:0] pc_data_r;
    logic [7:0] pc_dir_r;
    logic [3:0] bit_op_r;
    logic bit_op_pend_r;
    logic [7:0] rdata_nxt;
    logic [7:0] rmw_val;
    logic [7:0] rmw_nxt;
    logic [7:0] pa_out_nxt;
    logic [7:0] pa_oe_nxt;
    logic [7:0] pb_out_nxt;
    logic [7:0] pb_oe_nxt;
    logic pc0_out_nxt;
    logic pc0_oe_nxt;
    psfs_pkg::psfs_periph_in_t pin_nxt;
    psfs_pkg::psfs_analog_t ana_nxt;
    psfs_pkg::psfs_sel_t pa3_sel_field;
    psfs_pkg::psfs_sel_t pa1_sel_field;
    psfs_pkg::psfs_sel_t pa7_sel_field;
    psfs_pkg::psfs_sel_t pa6_sel_field;
    psfs_pkg::psfs_sel_t pa5_sel_field;
    psfs_pkg::psfs_sel_t pa4_sel_field;
    psfs_pkg::psfs_sel_t pb3_sel_field;
    psfs_pkg::psfs_sel_t pb2_sel_field;
    psfs_pkg::psfs_sel_t pb6_sel_field;
    psfs_pkg::psfs_sel_t pb5_sel_field;
    psfs_pkg::psfs_sel_t pb4_sel_field;
    psfs_pkg::psfs_sel_t pc0_sel_field;
    logic spi_din_source_bit;
    logic uart_rx_source_bit;
    logic wake_pulse;

    if (ADDR_W < 4)
        $error("psfs_pin_mux: ADDR_W must be at least 4");

    // field extraction
    assign pa3_sel_field = psfs_pkg::psfs_sel_t'(
        pa_sel_lo_r[psfs_pkg::POS_PA3 +: 2]);
    assign pa1_sel_field = psfs_pkg::psfs_sel_t'(
        pa_sel_lo_r[psfs_pkg::POS_PA1 +: 2]);
    assign pa7_sel_field = psfs_pkg::psfs_sel_t'(
        pa_sel_hi_r[psfs_pkg::POS_PA7 +: 2]);
    assign pa6_sel_field = psfs_pkg::psfs_sel_t'(
        pa_sel_hi_r[psfs_pkg::POS_PA6 +: 2]);
    assign pa5_sel_field = psfs_pkg::psfs_sel_t'(
        pa_sel_hi_r[psfs_pkg::POS_PA5 +: 2]);
    assign pa4_sel_field = psfs_pkg::psfs_sel_t'(
        pa_sel_hi_r[psfs_pkg::POS_PA4 +: 2]);
    assign pb3_sel_field = psfs_pkg::psfs_sel_t'(
        pb_sel_lo_r[psfs_pkg::POS_PB3 +: 2]);
    assign pb2_sel_field = psfs_pkg::psfs_sel_t'(
        pb_sel_lo_r[psfs_pkg::POS_PB2 +: 2]);
    assign pb6_sel_field = psfs_pkg::psfs_sel_t'(
        pb_sel_hi_r[psfs_pkg::POS_PB6 +: 2]);
    assign pb5_sel_field = psfs_pkg::psfs_sel_t'(
        pb_sel_hi_r[psfs_pkg::POS_PB5 +: 2]);
    assign pb4_sel_field = psfs_pkg::psfs_sel_t'(
        pb_sel_hi_r[psfs_pkg::POS_PB4 +: 2]);
    assign pc0_sel_field = psfs_pkg::psfs_sel_t'(
        pc_sel_r[psfs_pkg::POS_PC0 +: 2]);
    assign spi_din_source_bit = in_src_r[psfs_pkg::POS_SPI_SRC];
    assign uart_rx_source_bit = in_src_r[psfs_pkg::POS_RX_SRC];

    // selection registers, masked to implemented bits
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pa_sel_lo_r <= psfs_pkg::RST_SEL;
            pa_sel_hi_r <= psfs_pkg::RST_SEL;
            pb_sel_lo_r <= psfs_pkg::RST_SEL;
            pb_sel_hi_r <= psfs_pkg::RST_SEL;
            pc_sel_r <= psfs_pkg::RST_SEL;
            in_src_r <= psfs_pkg::RST_SEL;
            disp_sel_r <= psfs_pkg::RST_SEL;
        end
        else if (wr_in)
        begin
            unique case (addr_in[3:0])
                psfs_pkg::ADDR_PA_SEL_LO:
                    pa_sel_lo_r <= wdata_in & psfs_pkg::MASK_PA_SEL_LO;
                psfs_pkg::ADDR_PA_SEL_HI:
                    pa_sel_hi_r <= wdata_in & psfs_pkg::MASK_PA_SEL_HI;
                psfs_pkg::ADDR_PB_SEL_LO:
                    pb_sel_lo_r <= wdata_in & psfs_pkg::MASK_PB_SEL_LO;
                psfs_pkg::ADDR_PB_SEL_HI:
                    pb_sel_hi_r <= wdata_in & psfs_pkg::MASK_PB_SEL_HI;
                psfs_pkg::ADDR_PC_SEL:
                    pc_sel_r <= wdata_in & psfs_pkg::MASK_SMALL_SEL;
                psfs_pkg::ADDR_IN_SRC_SEL:
                    in_src_r <= wdata_in & psfs_pkg::MASK_SMALL_SEL;
                psfs_pkg::ADDR_DISP_SEL:
                    disp_sel_r <= wdata_in & psfs_pkg::MASK_SMALL_SEL;
                default: ;
            endcase
        end
    end

    // bit-op command: latched, applied next cycle as read-modify-write
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            bit_op_r <= 4'h0;
            bit_op_pend_r <= 1'b0;
        end
        else
        begin
            bit_op_pend_r <= wr_in && addr_in[3:0] == psfs_pkg::ADDR_BIT_OP;
            if (wr_in && addr_in[3:0] == psfs_pkg::ADDR_BIT_OP)
                bit_op_r <= wdata_in[3:0];
        end
    end

    // whole-byte read of port a data, one bit changed
    always_comb
    begin
        rmw_val = pa_data_r;
        if (bit_op_r[psfs_pkg::POS_BIT_SET])
            rmw_nxt = rmw_val | (8'h01 << bit_op_r[2:0]);
        else
            rmw_nxt = rmw_val & ~(8'h01 << bit_op_r[2:0]);
    end

    // port data, direction and wake-enable registers
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pa_data_r <= psfs_pkg::RST_PORT;
            pa_dir_r <= psfs_pkg::RST_PORT;
            pb_data_r <= psfs_pkg::RST_PORT;
            pb_dir_r <= psfs_pkg::RST_PORT;
            pc_data_r <= psfs_pkg::MASK_PC_PORT;
            pc_dir_r <= psfs_pkg::MASK_PC_PORT;
            pa_wake_r <= psfs_pkg::RST_WAKE;
        end
        else if (bit_op_pend_r)
            pa_data_r <= rmw_nxt;
        else if (wr_in)
        begin
            unique case (addr_in[3:0])
                psfs_pkg::ADDR_PA_DATA: pa_data_r <= wdata_in;
                psfs_pkg::ADDR_PA_DIR: pa_dir_r <= wdata_in;
                psfs_pkg::ADDR_PA_WAKE: pa_wake_r <= wdata_in;
                psfs_pkg::ADDR_PB_DATA: pb_data_r <= wdata_in;
                psfs_pkg::ADDR_PB_DIR: pb_dir_r <= wdata_in;
                psfs_pkg::ADDR_PC_DATA:
                    pc_data_r <= wdata_in & psfs_pkg::MASK_PC_PORT;
                psfs_pkg::ADDR_PC_DIR:
                    pc_dir_r <= wdata_in & psfs_pkg::MASK_PC_PORT;
                default: ;
            endcase
        end
    end

    // read mux; output pins read the latch
    always_comb
    begin
        rdata_nxt = 8'h00;
        unique case (addr_in[3:0])
            psfs_pkg::ADDR_PA_SEL_LO: rdata_nxt = pa_sel_lo_r;
            psfs_pkg::ADDR_PA_SEL_HI: rdata_nxt = pa_sel_hi_r;
            psfs_pkg::ADDR_PB_SEL_LO: rdata_nxt = pb_sel_lo_r;
            psfs_pkg::ADDR_PB_SEL_HI: rdata_nxt = pb_sel_hi_r;
            psfs_pkg::ADDR_PC_SEL: rdata_nxt = pc_sel_r;
            psfs_pkg::ADDR_IN_SRC_SEL: rdata_nxt = in_src_r;
            psfs_pkg::ADDR_DISP_SEL: rdata_nxt = disp_sel_r;
            psfs_pkg::ADDR_PA_DATA:
                rdata_nxt = (pa_dir_r & pa_pin_in) | (~pa_dir_r & pa_data_r);
            psfs_pkg::ADDR_PA_DIR: rdata_nxt = pa_dir_r;
            psfs_pkg::ADDR_PA_WAKE: rdata_nxt = pa_wake_r;
            psfs_pkg::ADDR_PB_DATA:
                rdata_nxt = (pb_dir_r & pb_pin_in) | (~pb_dir_r & pb_data_r);
            psfs_pkg::ADDR_PB_DIR: rdata_nxt = pb_dir_r;
            psfs_pkg::ADDR_PC_DATA:
                rdata_nxt = {7'h00, pc_dir_r[0] ? pc0_pin_in : pc_data_r[0]};
            psfs_pkg::ADDR_PC_DIR: rdata_nxt = pc_dir_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // read data valid the cycle after the strobe only
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rdata_out <= 8'h00;
        else if (rd_in)
            rdata_out <= rdata_nxt;
        else
            rdata_out <= 8'h00;
    end

    // output drivers: gpio by default, peripheral where selected
    always_comb
    begin
        pa_out_nxt = pa_data_r;
        pa_oe_nxt = ~pa_dir_r;
        pb_out_nxt = pb_data_r;
        pb_oe_nxt = ~pb_dir_r;
        pc0_out_nxt = pc_data_r[0];
        pc0_oe_nxt = ~pc_dir_r[0];
        ana_nxt = '0;
        unique case (pa3_sel_field)
            psfs_pkg::PSFS_SEL_01:
            begin
                pa_out_nxt[3] = periph_in.timer1_out;
                pa_oe_nxt[3] = 1'b1;
            end
            psfs_pkg::PSFS_SEL_10:
            begin
                pa_oe_nxt[3] = 1'b0;
                ana_nxt.analog_ch7 = 1'b1;
            end
            default: ;
        endcase
        if (pa1_sel_field == psfs_pkg::PSFS_SEL_10)
        begin
            pa_oe_nxt[1] = 1'b0;
            ana_nxt.analog_ch6 = 1'b1;
        end
        unique case (pa7_sel_field)
            psfs_pkg::PSFS_SEL_01:
            begin
                pa_out_nxt[7] = periph_in.timer0_out_inv;
                pa_oe_nxt[7] = 1'b1;
            end
            psfs_pkg::PSFS_SEL_10,
            psfs_pkg::PSFS_SEL_11: pa_oe_nxt[7] = 1'b0;
            default: ;
        endcase
        unique case (pa6_sel_field)
            psfs_pkg::PSFS_SEL_01:
            begin
                pa_out_nxt[6] = periph_in.serial_periph_dout;
                pa_oe_nxt[6] = 1'b1;
            end
            psfs_pkg::PSFS_SEL_10:
            begin
                pa_out_nxt[6] = periph_in.uart_tx;
                pa_oe_nxt[6] = 1'b1;
            end
            default: ;
        endcase
        unique case (pa5_sel_field)
            psfs_pkg::PSFS_SEL_01:
            begin
                pa_out_nxt[5] = periph_in.timer1_out_inv;
                pa_oe_nxt[5] = 1'b1;
            end
            psfs_pkg::PSFS_SEL_10:
            begin
                pa_out_nxt[5] = periph_in.serial_periph_cs;
                pa_oe_nxt[5] = 1'b1;
            end
            default: ;
        endcase
        if (pa4_sel_field == psfs_pkg::PSFS_SEL_01)
        begin
            pa_out_nxt[4] = periph_in.serial_periph_clk;
            pa_oe_nxt[4] = 1'b1;
        end
        if (pb3_sel_field == psfs_pkg::PSFS_SEL_01)
        begin
            pb_oe_nxt[3] = 1'b0;
            ana_nxt.amp_pos_in = 1'b1;
        end
        if (pb2_sel_field == psfs_pkg::PSFS_SEL_01)
        begin
            pb_oe_nxt[2] = 1'b0;
            ana_nxt.low_volt_detect_in = 1'b1;
        end
        unique case (pb6_sel_field)
            psfs_pkg::PSFS_SEL_01:
            begin
                pb_out_nxt[6] = periph_in.serial_periph_dout;
                pb_oe_nxt[6] = 1'b1;
            end
            psfs_pkg::PSFS_SEL_10:
            begin
                pb_out_nxt[6] = periph_in.uart_tx;
                pb_oe_nxt[6] = 1'b1;
            end
            default: ;
        endcase
        unique case (pb5_sel_field)
            psfs_pkg::PSFS_SEL_00: ;
            psfs_pkg::PSFS_SEL_11:
            begin
                pb_oe_nxt[5] = 1'b0;
                ana_nxt.analog_ch5 = 1'b1;
            end
            default: pb_oe_nxt[5] = 1'b0;
        endcase
        unique case (pb4_sel_field)
            psfs_pkg::PSFS_SEL_01:
            begin
                pb_oe_nxt[4] = 1'b0;
                ana_nxt.amp_neg_in = 1'b1;
            end
            psfs_pkg::PSFS_SEL_10:
            begin
                pb_oe_nxt[4] = 1'b0;
                ana_nxt.analog_ch4 = 1'b1;
            end
            default: ;
        endcase
        if (pc0_sel_field == psfs_pkg::PSFS_SEL_01)
        begin
            pc0_out_nxt = periph_in.timer0_out;
            pc0_oe_nxt = 1'b1;
        end
    end

    // peripheral inputs; shared gpio inputs rely on software direction
    always_comb
    begin
        pin_nxt.serial_periph_din = spi_din_source_bit ? pa_pin_in[7]
                                                       : pb_pin_in[5];
        pin_nxt.uart_rx = uart_rx_source_bit ? pb_pin_in[5]
                                             : pa_pin_in[7];
        pin_nxt.ext_irq_0 = (pa1_sel_field != psfs_pkg::PSFS_SEL_10)
                            & pa_pin_in[1];
        pin_nxt.ext_irq_1 = (pb2_sel_field != psfs_pkg::PSFS_SEL_01)
                            & pb_pin_in[2];
        pin_nxt.timer0_clk_in = (pb4_sel_field == psfs_pkg::PSFS_SEL_00 ||
                                 pb4_sel_field == psfs_pkg::PSFS_SEL_11)
                                & pb_pin_in[4];
    end

    // registered pin, analog and lcd outputs
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pa_pin_out <= psfs_pkg::RST_PORT;
            pa_pin_oe_out <= 8'h00;
            pb_pin_out <= psfs_pkg::RST_PORT;
            pb_pin_oe_out <= 8'h00;
            pc0_pin_out <= 1'b1;
            pc0_pin_oe_out <= 1'b0;
            periph_out <= '0;
            analog_sel_out <= '0;
            lcd_common_5_sel_out <= 1'b0;
            lcd_common_4_sel_out <= 1'b0;
        end
        else
        begin
            pa_pin_out <= pa_out_nxt;
            pa_pin_oe_out <= pa_oe_nxt;
            pb_pin_out <= pb_out_nxt;
            pb_pin_oe_out <= pb_oe_nxt;
            pc0_pin_out <= pc0_out_nxt;
            pc0_pin_oe_out <= pc0_oe_nxt;
            periph_out <= pin_nxt;
            analog_sel_out <= ana_nxt;
            lcd_common_5_sel_out <= disp_sel_r[psfs_pkg::POS_LCD_SEGMENT_30];
            lcd_common_4_sel_out <= disp_sel_r[psfs_pkg::POS_LCD_SEGMENT_31];
        end
    end

    // wake only from port a pins with wake enabled and direction set to input, whatever their selection
    psfs_wake_det #(
        .WIDTH(8)
    ) u_wake (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(pa_pin_in),
        .enable_in(pa_wake_r & pa_dir_r),
        .sleep_in(sleep_in),
        .wake_out(wake_pulse)
    );

    assign wake_out = wake_pulse;

endmodule : psfs_pin_mux

// ---- core/psfs_pkg.sv ----
package psfs_pkg;

    // register indices on the plain register port
    localparam logic [3:0] ADDR_PA_SEL_LO = 4'h0;
    localparam logic [3:0] ADDR_PA_SEL_HI = 4'h1;
    localparam logic [3:0] ADDR_PB_SEL_LO = 4'h2;
    localparam logic [3:0] ADDR_PB_SEL_HI = 4'h3;
    localparam logic [3:0] ADDR_PC_SEL = 4'h4;
    localparam logic [3:0] ADDR_IN_SRC_SEL = 4'h5;
    localparam logic [3:0] ADDR_DISP_SEL = 4'h6;
    localparam logic [3:0] ADDR_PA_DATA = 4'h8;
    localparam logic [3:0] ADDR_PA_DIR = 4'h9;
    localparam logic [3:0] ADDR_PA_WAKE = 4'hA;
    localparam logic [3:0] ADDR_PB_DATA = 4'hB;
    localparam logic [3:0] ADDR_PB_DIR = 4'hC;
    localparam logic [3:0] ADDR_PC_DATA = 4'hD;
    localparam logic [3:0] ADDR_PC_DIR = 4'hE;
    localparam logic [3:0] ADDR_BIT_OP = 4'hF;

    // implemented-bit masks of the selection registers and the port c registers
    localparam logic [7:0] MASK_PA_SEL_LO = 8'hCC;
    localparam logic [7:0] MASK_PA_SEL_HI = 8'hFF;
    localparam logic [7:0] MASK_PB_SEL_LO = 8'hF0;
    localparam logic [7:0] MASK_PB_SEL_HI = 8'h3F;
    localparam logic [7:0] MASK_SMALL_SEL = 8'h03;
    localparam logic [7:0] MASK_PC_PORT = 8'h01;

    // reset values
    localparam logic [7:0] RST_SEL = 8'h00;
    localparam logic [7:0] RST_PORT = 8'hFF;
    localparam logic [7:0] RST_WAKE = 8'h00;

    // field positions (low bit of each two-bit field; the source and lcd selects are single bits)
    localparam int POS_PA3 = 6;
    localparam int POS_PA1 = 2;
    localparam int POS_PA7 = 6;
    localparam int POS_PA6 = 4;
    localparam int POS_PA5 = 2;
    localparam int POS_PA4 = 0;
    localparam int POS_PB3 = 6;
    localparam int POS_PB2 = 4;
    localparam int POS_PB6 = 4;
    localparam int POS_PB5 = 2;
    localparam int POS_PB4 = 0;
    localparam int POS_PC0 = 0;
    localparam int POS_SPI_SRC = 1;
    localparam int POS_RX_SRC = 0;
    localparam int POS_LCD_SEGMENT_30 = 1;
    localparam int POS_LCD_SEGMENT_31 = 0;

    // bit-operation command layout: [3] set/clear, [2:0] bit index
    localparam int POS_BIT_SET = 3;

    // pin function per selection code
    typedef enum logic [1:0] {
        PSFS_SEL_00,
        PSFS_SEL_01,
        PSFS_SEL_10,
        PSFS_SEL_11
    } psfs_sel_t;

    // peripheral outputs and enables seen by the mux
    typedef struct packed {
        logic timer0_out;
        logic timer0_out_inv;
        logic timer1_out;
        logic timer1_out_inv;
        logic serial_periph_dout;
        logic serial_periph_cs;
        logic serial_periph_clk;
        logic uart_tx;
    } psfs_periph_t;

    // inputs delivered to peripherals
    typedef struct packed {
        logic serial_periph_din;
        logic uart_rx;
        logic ext_irq_0;
        logic ext_irq_1;
        logic timer0_clk_in;
    } psfs_periph_in_t;

    // analog switch enables
    typedef struct packed {
        logic analog_ch4;
        logic analog_ch5;
        logic analog_ch6;
        logic analog_ch7;
        logic amp_pos_in;
        logic amp_neg_in;
        logic low_volt_detect_in;
    } psfs_analog_t;

endpackage : psfs_pkg

// ---- core/psfs_wake_det.sv ----
`timescale 1ns/1ps

// falling-edge wake detector over an enabled group of pins
module psfs_wake_det #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0] enable_in,
    input wire logic sleep_in,
    output logic wake_out
);

    logic [WIDTH-1:0] prev_r;
    logic [WIDTH-1:0] fall;

    if (WIDTH < 1)
        $error("psfs_wake_det: WIDTH must be at least 1");

    // previous pin levels; idle-high so reset is no edge
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            prev_r <= '1;
        else
            prev_r <= pin_in;
    end

    // per-pin high-to-low detect
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_fall
        assign fall[i] = prev_r[i] & ~pin_in[i] & enable_in[i];
    end

    // wake pulse only while sleeping
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            wake_out <= 1'b0;
        else
            wake_out <= sleep_in & (|fall);
    end

endmodule : psfs_wake_det

// ---- tb/psfs_monitor.sv ----
`timescale 1ns/1ps
// port-level checks on the pin mux
module psfs_monitor #(
    parameter int ADDR_W = 4
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic [7:0] pa_pin_in,
    input wire logic [7:0] pa_pin_oe_out,
    input wire psfs_pkg::psfs_periph_in_t periph_out,
    input wire psfs_pkg::psfs_analog_t analog_sel_out,
    input wire logic lcd_common_5_sel_out,
    input wire logic lcd_common_4_sel_out,
    input wire logic sleep_in,
    input wire logic wake_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    // decoded strobes
    wire disp_w = wr_in && addr_in == psfs_pkg::ADDR_DISP_SEL;
    wire small_rd = rd_in && addr_in inside {[4'h4:4'h6]};
    // display select written, then left alone a cycle
    sequence disp_set;
        disp_w ##1 !disp_w;
    endsequence
    chk_lcd_common_5_follow: assert property (disp_set |=>
        lcd_common_5_sel_out == $past(wdata_in[1], 2)) else $error("lcd_common_5");
    chk_lcd_common_4_follow: assert property (disp_set |=>
        lcd_common_4_sel_out == $past(wdata_in[0], 2)) else $error("lcd_common_4");
    chk_rdata_idle: assert property (!$past(rd_in) |->
        rdata_out == 8'h00) else $error("rdata not idle");
    chk_small_regs: assert property (small_rd |=>
        rdata_out[7:2] == 6'h00) else $error("unused bits set");
    chk_analog_float: assert property (
        !(analog_sel_out.analog_ch7 && pa_pin_oe_out[3]) &&
        !(analog_sel_out.analog_ch6 && pa_pin_oe_out[1]))
        else $error("analog pin driven");
    chk_irq0_path: assert property ($past(rst_b_in) &&
        !analog_sel_out.analog_ch6 && !pa_pin_oe_out[1] |->
        periph_out.ext_irq_0 == $past(pa_pin_in[1])) else $error("irq0");
    chk_wake_awake: assert property (!$past(sleep_in) &&
        !$past(sleep_in, 2) |-> !wake_out) else $error("wake awake");
    chk_reset_float: assert property (disable iff (1'b0)
        !rst_b_in |-> pa_pin_oe_out == 8'h00 && analog_sel_out == '0)
        else $error("driven in reset");
endmodule : psfs_monitor
bind psfs_pin_mux psfs_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk_in,
    .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .pa_pin_in, .pa_pin_oe_out, .periph_out, .analog_sel_out,
    .lcd_common_5_sel_out, .lcd_common_4_sel_out, .sleep_in, .wake_out);

// ---- tb/psfs_far_end.sv ----
`timescale 1ns/1ps
// pads and peripherals beside the pin mux
module psfs_far_end (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [16:0] ext_in,
    input wire logic [16:0] out_in,
    input wire logic [16:0] oe_in,
    output logic [16:0] pad_out,
    output psfs_pkg::psfs_periph_t periph_out
);
    logic [7:0] cnt_r;
    // peripheral outputs change every cycle
    always_ff @(posedge clk_in or negedge rst_b_in)
        if (!rst_b_in)
            cnt_r <= 8'h00;
        else
            cnt_r <= cnt_r + 8'h5B;
    assign periph_out = psfs_pkg::psfs_periph_t'(cnt_r);
    // pad follows the mux when driven, else the outside level
    assign pad_out = (oe_in & out_in) | (~oe_in & ext_in);
endmodule : psfs_far_end

// ---- tb/test_pin_shared_function_select.sv ----
`timescale 1ns/1ps
module test_pin_shared_function_select;
    localparam logic [63:0] MASKS = 64'h00030303_3FF0FFCC;
    logic clk_in = 1'b0;
    logic rst_b_in;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic sleep_in = 1'b0;
    logic [16:0] ext = 17'h1FFFF;
    wire [16:0] pout;
    wire [16:0] poe;
    logic [16:0] pad;
    logic [7:0] rdata_out;
    logic wake_out;
    logic lcd_common_5;
    logic lcd_common_4;
    psfs_pkg::psfs_periph_t per;
    psfs_pkg::psfs_periph_t prv;
    psfs_pkg::psfs_periph_in_t pfn;
    psfs_pkg::psfs_analog_t ana;
    int err_count = 0;
    int samples_checked = 0;
    // clock and last cycle's peripheral outputs
    initial forever #50 clk_in = ~clk_in;
    always @(negedge clk_in) prv <= per;
    psfs_pin_mux u_dut (.clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in,
        .rd_in, .rdata_out, .pa_pin_in(pad[7:0]), .pa_pin_out(pout[7:0]),
        .pa_pin_oe_out(poe[7:0]), .pb_pin_in(pad[15:8]),
        .pb_pin_out(pout[15:8]), .pb_pin_oe_out(poe[15:8]),
        .pc0_pin_in(pad[16]), .pc0_pin_out(pout[16]),
        .pc0_pin_oe_out(poe[16]), .periph_in(per), .periph_out(pfn),
        .analog_sel_out(ana), .lcd_common_5_sel_out(lcd_common_5),
        .lcd_common_4_sel_out(lcd_common_4), .sleep_in, .wake_out);
    psfs_far_end u_far (.clk_in, .rst_b_in, .ext_in(ext), .out_in(pout),
        .oe_in(poe), .pad_out(pad), .periph_out(per));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        chk(rdata_out, exp);
    endtask : rd
    task automatic settle;
        repeat (2) @(negedge clk_in);
    endtask : settle
    // reset values, unused bits and the spare index
    task automatic t_regs;
        for (int a = 0; a < 7; a++)
            rd(4'(a), 8'h00);
        rd(4'hE, 8'h01);
        rd(4'hC, 8'hFF);
        for (int a = 0; a < 8; a++)
        begin
            wr(4'(a), 8'hFF);
            rd(4'(a), MASKS[a*8 +: 8]);
        end
        chk({lcd_common_5, lcd_common_4, ana[5], 5'h00}, 8'hE0);
    endtask : t_regs
    // peripheral outputs, then analog takes pins
    task automatic t_outs;
        wr(4'h1, 8'h65);
        wr(4'h0, 8'h40);
        wr(4'h3, 8'h10);
        wr(4'h4, 8'h01);
        wr(4'h6, 8'h02);
        settle();
        repeat (3)
        begin
            @(negedge clk_in);
            chk({poe[7:3], poe[14], poe[16], lcd_common_5}, 8'hFF);
            chk({pout[7:3], pout[14], pout[16], 1'b0},
                {prv.timer0_out_inv, prv.uart_tx, prv.timer1_out_inv,
                prv.serial_periph_clk, prv.timer1_out,
                prv.serial_periph_dout, prv.timer0_out, 1'b0});
        end
        wr(4'hC, 8'h00);
        wr(4'h1, 8'h98);
        wr(4'h3, 8'h25);
        settle();
        chk({pout[6:5], pout[14], poe[7], poe[13:12], ana.amp_neg_in, 1'b0},
            {prv.serial_periph_dout, prv.serial_periph_cs, prv.uart_tx,
            5'h02});
        wr(4'h0, 8'h88);
        wr(4'h2, 8'h50);
        wr(4'h3, 8'h0A);
        wr(4'h6, 8'h01);
        settle();
        chk({ana, lcd_common_4}, 8'hBB);
        chk({pfn.ext_irq_0, pfn.ext_irq_1, pfn.timer0_clk_in, lcd_common_5,
            poe[3], poe[1], poe[11:10]}, 8'h00);
    endtask : t_outs
    // serial data and receive input sources
    task automatic t_src;
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h00);
        wr(4'h5, 8'h00);
        ext <= 17'h1FF7F;
        settle();
        chk({6'h00, pfn.serial_periph_din, pfn.uart_rx}, 8'h02);
        wr(4'h5, 8'h03);
        settle();
        chk({6'h00, pfn.serial_periph_din, pfn.uart_rx}, 8'h01);
        ext <= 17'h1FFFF;
    endtask : t_src
    // bit set and clear on port a data
    task automatic t_bit;
        wr(4'h9, 8'h00);
        wr(4'h8, 8'h00);
        wr(4'hF, 8'h0B);
        @(posedge clk_in);
        rd(4'h8, 8'h08);
        chk(pout[7:0], 8'h08);
        wr(4'hF, 8'h03);
        @(posedge clk_in);
        rd(4'h8, 8'h00);
    endtask : t_bit
    // falling edge on an enabled pin while asleep
    task automatic t_wake;
        logic seen;
        seen = 1'b0;
        wr(4'h9, 8'hFF);
        wr(4'hA, 8'h01);
        sleep_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        ext <= 17'h1FFFE;
        repeat (6)
        begin
            @(negedge clk_in);
            seen = seen | wake_out;
        end
        chk({7'h00, seen}, 8'h01);
        @(posedge clk_in);
        sleep_in <= 1'b0;
        ext <= 17'h1FFFF;
    endtask : t_wake
    task automatic finish_test;
        if (err_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    // main sequence
    initial
    begin
        rst_b_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_regs();
        t_outs();
        t_src();
        t_bit();
        t_wake();
        finish_test();
    end
    // watchdog far beyond the expected run
    initial
    begin
        #200000;
        err_count++;
        finish_test();
    end
endmodule : test_pin_shared_function_select
